// *** shared/dcs_pkg.sv ***
// Package for the DMA count and collision status block.
// Assumes a 16-bit register port and eight DMA channel engines outside.
package dcs_pkg;

	localparam int unsigned NUM_CH     = 8;
	localparam int unsigned CNT_W      = 10;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned ADDR_W     = 4;

	// Register indices on the plain register port.
	localparam logic [3:0]  IDX_CNT0       = 4'h0; // Count registers of channels 0..7 at 0..7.
	localparam logic [3:0]  IDX_COLL_STS   = 4'h8;
	localparam logic [3:0]  IDX_COLL_MASK  = 4'h9;
	localparam logic [3:0]  IDX_DONE_STS   = 4'hA;
	localparam logic [3:0]  IDX_DONE_MASK  = 4'hB;

	// Field positions of the collision status register.
	localparam int unsigned RAM_COL_LSB    = 0;
	localparam int unsigned PER_COL_LSB    = 8;

	// Reset values.
	localparam logic [9:0]  CNT_RST        = 10'h000;
	localparam logic [15:0] COLL_RST       = 16'h0000;
	localparam logic [15:0] MASK_RST       = 16'h0000;
	localparam logic [7:0]  DONE_RST       = 8'h00;

	// One register port access.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} dcs_bus_req_t;

	// Collision events from channel engines, one pulse bit per channel.
	typedef struct packed {
		logic [7:0] per_col;
		logic [7:0] ram_col;
	} dcs_coll_evt_t;

endpackage

// *** hdl/dcs_chan.sv ***
// Per-channel transfer counter of the DMA count block.
// Assumes one-cycle transfer pulses from the channel engine, synchronous to i_clk_sys.
`timescale 1ns/1ns
`default_nettype none

module dcs_chan
	import dcs_pkg::*;
#(
	parameter int unsigned W = CNT_W
) (
	// Clock and reset.
	input  wire logic         i_clk_sys,
	input  wire logic         i_rstn,
	// Programmed count and channel progress.
	input  wire logic [W-1:0] i_count,
	input  wire logic         i_enable,
	input  wire logic         i_xfer,
	// Block complete pulse.
	output var  logic         o_done
);

	typedef struct packed {
		logic [W-1:0] progress;
		logic         done;
	} dcs_chan_st_t;

	dcs_chan_st_t st;
	dcs_chan_st_t next_st;

	// Count transfers; the block ends after count plus one of them.
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		if (!i_enable) begin
			next_st.progress = '0;
		end else if (i_xfer) begin
			if (st.progress == i_count) begin
				next_st.done     = 1'b1;
				next_st.progress = '0;
			end else begin
				next_st.progress = st.progress + W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_done = st.done;

	// Transfers seen since the last completion, for checking only.
	logic [W:0] seen;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			seen <= '0;
		end else if (!i_enable || o_done) begin
			seen <= (i_enable && i_xfer) ? (W+1)'(1) : '0;
		end else if (i_xfer) begin
			seen <= seen + (W+1)'(1);
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	a_done_after_count: assert property (
		o_done |-> seen == {1'b0, $past(i_count)} + (W+1)'(1))
		else $error("Completion not after count plus one transfers.");
	a_zero_single_xfer: assert property (
		(i_enable && i_xfer && i_count == '0) |=> o_done)
		else $error("Zero count did not complete after one transfer.");
	a_no_done_idle: assert property (
		!$past(i_enable) |-> !o_done)
		else $error("Completion while channel disabled.");

	c_chan_done: cover property (i_enable && i_xfer ##1 o_done);

endmodule

`default_nettype wire

// *** hdl/dcs_top.sv ***
// Transfer count registers and collision status of an eight-channel DMA controller.
// Assumes software on a plain register port and channel engines that pulse transfer
// and collision events synchronously to i_clk_sys.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Each channel has a 10-bit read/write transfer count in bits 9..0, zero after reset.
// - Bits 15..10 of each count register read as zero and ignore writes.
// - A channel completes after exactly its programmed count plus one transfers.
// - Status bits 15..8 are per-channel peripheral write collision flags for channels 7..0.
// - Status bits 7..0 are per-channel DMA RAM write collision flags for channels 7..0.
module dcs_top
	import dcs_pkg::*;
#(
	parameter int unsigned N_CH = NUM_CH
) (
	// Clock and reset.
	input  wire logic              i_clk_sys,
	input  wire logic              i_rstn,
	// Register port.
	input  wire dcs_bus_req_t      i_bus,
	output var  logic [15:0]       o_rdata,
	// Channel engine side.
	input  wire logic [N_CH-1:0]   i_ch_enable,
	input  wire logic [N_CH-1:0]   i_ch_xfer,
	input  wire dcs_coll_evt_t     i_coll,
	output var  logic [N_CH-1:0]   o_ch_done,
	// Interrupt.
	output var  logic              o_irq
);

	typedef struct packed {
		logic [N_CH-1:0][CNT_W-1:0] cnt;
		logic [15:0]                coll;
		logic [15:0]                coll_mask;
		logic [7:0]                 done_sts;
		logic [7:0]                 done_mask;
		logic [15:0]                rdata;
		logic                       irq;
	} dcs_top_st_t;

	dcs_top_st_t st;
	dcs_top_st_t next_st;

	logic [N_CH-1:0] ch_done;
	logic [15:0]     coll_set;
	logic            wr_coll;

	assign coll_set = {i_coll.per_col, i_coll.ram_col};
	assign wr_coll  = i_bus.wr && i_bus.addr == IDX_COLL_STS;

	// One counter per channel consumes that channel's programmed count.
	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		dcs_chan #(
			.W (CNT_W)
		) u_chan (
			.i_clk_sys (i_clk_sys),
			.i_rstn    (i_rstn),
			.i_count   (st.cnt[g]),
			.i_enable  (i_ch_enable[g]),
			.i_xfer    (i_ch_xfer[g]),
			.o_done    (ch_done[g])
		);
	end

	assign o_ch_done = ch_done;

	// Register writes, sticky event flags, read data and interrupt.
	always_comb begin
		next_st       = st;
		next_st.rdata = 16'h0000;
		if (i_bus.wr) begin
			if (i_bus.addr < ADDR_W'(N_CH)) begin
				next_st.cnt[i_bus.addr[2:0]] = i_bus.wdata[CNT_W-1:0];
			end
			if (i_bus.addr == IDX_COLL_MASK) begin
				next_st.coll_mask = i_bus.wdata;
			end
			if (i_bus.addr == IDX_DONE_STS) begin
				next_st.done_sts = st.done_sts & ~i_bus.wdata[7:0];
			end
			if (i_bus.addr == IDX_DONE_MASK) begin
				next_st.done_mask = i_bus.wdata[7:0];
			end
		end
		// Writing zero clears a collision flag; a set in the same cycle wins.
		next_st.coll = (wr_coll ? (st.coll & i_bus.wdata) : st.coll) | coll_set;
		next_st.done_sts = next_st.done_sts | 8'(ch_done);
		if (i_bus.rd) begin
			if (i_bus.addr < ADDR_W'(N_CH)) begin
				next_st.rdata = {6'h00, st.cnt[i_bus.addr[2:0]]};
			end else begin
				unique case (i_bus.addr)
					IDX_COLL_STS:  next_st.rdata = st.coll;
					IDX_COLL_MASK: next_st.rdata = st.coll_mask;
					IDX_DONE_STS:  next_st.rdata = {8'h00, st.done_sts};
					IDX_DONE_MASK: next_st.rdata = {8'h00, st.done_mask};
					default:       next_st.rdata = 16'h0000;
				endcase
			end
		end
		next_st.irq = |(next_st.coll & next_st.coll_mask)
			| |(next_st.done_sts & next_st.done_mask);
	end

	// State register; every flag and count clears on reset.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st.cnt       <= {N_CH{CNT_RST}};
			st.coll      <= COLL_RST;
			st.coll_mask <= MASK_RST;
			st.done_sts  <= DONE_RST;
			st.done_mask <= DONE_RST;
			st.rdata     <= 16'h0000;
			st.irq       <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_irq   = st.irq;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	a_cnt_readback: assert property (
		(i_bus.wr && i_bus.addr == 4'h3) ##1 !i_bus.wr ##1 (i_bus.rd && i_bus.addr == 4'h3)
		|=> o_rdata == ($past(i_bus.wdata, 3) & 16'h03FF))
		else $error("Count register did not read back what was written.");
	a_cnt_high_zero: assert property (
		$past(i_bus.rd) && $past(i_bus.addr) < 4'h8 |-> o_rdata[15:10] == 6'h00)
		else $error("Unimplemented count bits read nonzero.");
	a_per_flag_set: assert property (
		i_coll.per_col[4] |=> st.coll[12])
		else $error("Peripheral collision did not set its flag.");
	a_ram_flag_set: assert property (
		i_coll.ram_col[3] |=> st.coll[3])
		else $error("RAM collision did not set its flag.");
	a_set_beats_clear: assert property (
		(wr_coll && i_bus.wdata == 16'h0000 && coll_set != 16'h0000)
		|=> st.coll == $past(coll_set))
		else $error("Clear overrode a collision set.");
	a_flag_holds: assert property (
		(st.coll[0] && !wr_coll) |=> st.coll[0])
		else $error("Collision flag dropped without a clear.");
	a_irq_level: assert property (
		o_irq == (|(st.coll & st.coll_mask) || |(st.done_sts & st.done_mask)))
		else $error("Interrupt does not follow masked status.");

	c_coll_clear: cover property (st.coll[9] ##1 wr_coll ##1 !st.coll[9]);
	c_irq_raise: cover property (!o_irq ##1 o_irq);
	c_read_status: cover property (i_bus.rd && i_bus.addr == IDX_COLL_STS && st.coll != 16'h0);

endmodule

`default_nettype wire

// *** verification/dcs_engine_model.sv ***
// Channel engine model that issues transfer pulses to the count block.
// Assumes the bench holds i_ch, i_n and i_slow steady during a burst.
`timescale 1ns/1ns
`default_nettype none

module dcs_engine_model (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// Burst request.
	input  wire logic        i_go,
	input  wire logic [2:0]  i_ch,
	input  wire logic [10:0] i_n,
	input  wire logic        i_slow,
	// Transfer pulses and activity.
	output var  logic [7:0]  o_xfer,
	output var  logic        o_busy
);
	logic [10:0] left;
	logic        gap;

	// Pulses every cycle, or every other cycle when slow.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			left <= 11'h000;
			gap <= 1'b0;
			o_xfer <= 8'h00;
		end else begin
			gap <= ~gap;
			if (i_go) begin
				left <= i_n;
				o_xfer <= 8'h00;
			end else if (left != 0 && (!i_slow || gap)) begin
				o_xfer <= 8'h01 << i_ch;
				left <= left - 11'h001;
			end else begin
				o_xfer <= 8'h00;
			end
		end
	end

	// Busy until the last pulse has left.
	assign o_busy = (left != 0) || (o_xfer != 0);
endmodule
`default_nettype wire

// *** verification/tb_dma_count_and_collision_status.sv ***
// Testbench for the count and collision status block.
// Assumes the engine model drives transfers and the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none

module tb_dma_count_and_collision_status;
	import dcs_pkg::*;
	logic           clk = 0, rstn = 0, go = 0, slow = 0, busy, irq;
	logic [2:0]     sel = 0;
	logic [10:0]    num = 0;
	logic [7:0]     enable = 0, xfer, done;
	logic [15:0]    rdata;
	dcs_bus_req_t   bus = '0;
	dcs_coll_evt_t  coll = '0;
	int             failures = 0, comparisons = 0, ndone = 0;

	// System clock and completion pulse counter.
	always #5 clk = ~clk;
	always @(posedge clk) ndone <= ndone + $countones(done);

	dcs_top i_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
		.i_ch_enable(enable), .i_ch_xfer(xfer), .i_coll(coll), .o_ch_done(done),
		.o_irq(irq));
	dcs_engine_model i_eng (.i_clk_sys(clk), .i_rstn(rstn), .i_go(go), .i_ch(sel),
		.i_n(num), .i_slow(slow), .o_xfer(xfer), .o_busy(busy));

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One write cycle, with optional collision pulses beside it.
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input dcs_coll_evt_t c = '0);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		coll <= c;
		@(posedge clk);
		bus <= '0;
		coll <= '0;
	endtask

	// One read cycle; data is judged in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		bus <= '0;
		#1 chk("rdata", e, rdata);
	endtask

	// Runs a burst on one channel and checks the completion count.
	task automatic burst(input logic [2:0] c, input logic [10:0] n, input logic s, input int e);
		int base;
		base = ndone;
		@(posedge clk);
		go <= 1'b1;
		sel <= c;
		num <= n;
		slow <= s;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (int i = 0; busy; i++) begin
			if (i > 60) begin
				failures++;
				wrap_up();
			end
			@(posedge clk) #1;
		end
		repeat (3) @(posedge clk);
		chk("done pulses", 16'(e), 16'(ndone - base));
	endtask

	task automatic t_regs();
		rd(IDX_CNT0, 16'h0000);
		rd(IDX_COLL_STS, 16'h0000);
		wr(4'h3, 16'hFFFF);
		rd(4'h3, 16'h03FF);
		wr(4'hC, 16'hFFFF);
		rd(4'hC, 16'h0000);
		rd(4'h3, 16'h03FF);
	endtask

	// Count writes happen only with the channel disabled.
	task automatic t_count();
		wr(4'h5, 16'h0002);
		enable <= 8'h21;
		burst(3'd5, 11'd2, 1'b1, 0);
		burst(3'd5, 11'd1, 1'b0, 1);
		burst(3'd0, 11'd1, 1'b0, 1);
		burst(3'd3, 11'd1, 1'b0, 0);
		burst(3'd5, 11'd2, 1'b0, 0);
		// Dropping the enable for one cycle discards the progress made so far.
		enable <= 8'h01;
		@(posedge clk);
		enable <= 8'h21;
		burst(3'd5, 11'd1, 1'b0, 0);
		burst(3'd5, 11'd2, 1'b0, 1);
		rd(IDX_DONE_STS, 16'h0021);
	endtask

	task automatic t_coll();
		wr(IDX_COLL_STS, 16'hFFFF, '{per_col: 8'h10, ram_col: 8'h08});
		rd(IDX_COLL_STS, 16'h1008);
		chk("irq masked", 16'h0000, 16'(irq));
		wr(IDX_COLL_MASK, 16'h0008);
		repeat (2) @(posedge clk);
		#1 chk("irq set", 16'h0001, 16'(irq));
		wr(IDX_COLL_STS, 16'hFFF7, '{per_col: 8'h00, ram_col: 8'h08});
		rd(IDX_COLL_STS, 16'h1008);
		wr(IDX_COLL_STS, 16'hFFF7);
		rd(IDX_COLL_STS, 16'h1000);
		#1 chk("irq clear", 16'h0000, 16'(irq));
		wr(IDX_COLL_STS, 16'h0000, '{per_col: 8'h02, ram_col: 8'h00});
		rd(IDX_COLL_STS, 16'h0200);
		wr(IDX_COLL_STS, 16'h0000);
		rd(IDX_COLL_STS, 16'h0000);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_count();
		t_coll();
		wrap_up();
	end
endmodule
`default_nettype wire
